// ---- hw/adc_ctrl_pkg.sv ----
// Package: register map, field layout and timing constants of the converter control
package adc_ctrl_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [3:0] OFS_PRIMARY = 4'h0;
	localparam logic [3:0] OFS_CONFIG = 4'h4;
	localparam logic [3:0] OFS_RES_HIGH = 4'h8;
	localparam logic [3:0] OFS_RES_LOW = 4'hc;
	localparam logic [7:0] PRIMARY_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_START = 7;
	localparam int BIT_BUSY = 6;
	localparam int BIT_POWER = 5;
	localparam int BIT_ALIGN = 4;
	localparam int SRC_LSB = 5;
	localparam int REF_LSB = 3;
	// ****************************************
	// Codes and timing
	// ****************************************
	localparam logic [2:0] SRC_AMPLIFIED = 3'h1;
	localparam logic [2:0] SRC_GND_LO = 3'h2;
	localparam logic [2:0] SRC_GND_HI = 3'h4;
	localparam logic [1:0] REF_SUPPLY = 2'h1;
	localparam logic [3:0] CHAN_LAST = 4'h6;
	localparam logic [4:0] SAMPLE_CLOCKS = 5'h04;
	localparam logic [4:0] CONVERT_CLOCKS = 5'h0c;
	localparam logic [4:0] TOTAL_CLOCKS = 5'h10;

	typedef struct packed {
		logic start;
		logic power;
		logic align;
		logic [3:0] channel;
	} primary_t;

	typedef struct packed {
		logic [2:0] source;
		logic [1:0] reference;
		logic [2:0] divider;
	} config_t;

	typedef struct packed {
		logic external;
		logic amplified;
		logic ground;
		logic [6:0] channelOn;
		logic supplyRef;
	} route_t;
endpackage

// ---- hw/adc_sequencer_control.sv ----
// Converter control: Avalon-MM registers, start detection, sequencer, routing
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control #(
	parameter int RESULT_BITS = 12
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [RESULT_BITS-1:0] converterData,
	output logic converterPower,
	output logic converterClockEn,
	output logic sampling,
	output adc_ctrl_pkg::route_t route,
	output logic conversionDone
);
	// ****************************************
	// Register state
	// ****************************************
	adc_ctrl_pkg::primary_t primary;
	adc_ctrl_pkg::config_t settings;
	logic busy;
	logic armed;
	logic [7:0] resultHigh;
	logic [7:0] resultLow;
	logic [4:0] clocks;
	logic [7:0] readByte;

	// Two-cycle slave: one wait cycle keeps readdata registered
	logic answered;
	wire request = read || write;
	assign waitrequest = request && !answered;
	wire writeTake = write && answered && byteenable[0];
	wire hitPrimary = address == adc_ctrl_pkg::OFS_PRIMARY;
	wire hitConfig = address == adc_ctrl_pkg::OFS_CONFIG;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			answered <= 1'b0;
		end else begin
			answered <= request && !answered;
		end
	end

	// ****************************************
	// Start sequence and sequencer
	// ****************************************
	// Start bit falling after a rise marks the request
	wire startWrite = writeTake && hitPrimary;
	wire newStart = writedata[adc_ctrl_pkg::BIT_START];
	wire startFall = startWrite && primary.start && !newStart && armed;
	wire launch = startFall && primary.power && !busy;
	wire tick;
	wire lastClock = busy && tick && clocks == adc_ctrl_pkg::TOTAL_CLOCKS - 5'h01;

	clock_divider divide (
		.mclk(mclk),
		.rst(rst),
		.run(busy),
		.divider(settings.divider),
		.tick(tick)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			primary <= {adc_ctrl_pkg::PRIMARY_RESET[7], adc_ctrl_pkg::PRIMARY_RESET[5:0]};
			settings <= adc_ctrl_pkg::CONFIG_RESET;
			armed <= 1'b0;
		end else if (startWrite) begin
			primary.start <= newStart;
			primary.power <= writedata[adc_ctrl_pkg::BIT_POWER];
			primary.align <= writedata[adc_ctrl_pkg::BIT_ALIGN];
			primary.channel <= writedata[3:0];
			armed <= newStart && !primary.start;
		end else if (writeTake && hitConfig) begin
			settings <= writedata[7:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			clocks <= 5'h00;
		end else if (!primary.power) begin
			busy <= 1'b0;
			clocks <= 5'h00;
		end else if (launch) begin
			busy <= 1'b1;
			clocks <= 5'h00;
		end else if (lastClock) begin
			busy <= 1'b0;
		end else if (busy && tick) begin
			clocks <= clocks + 5'h01;
		end
	end

	// Result captured in the same edge that clears busy
	wire [11:0] d = converterData[11:0];
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			resultHigh <= 8'h00;
			resultLow <= 8'h00;
		end else if (lastClock && primary.power) begin
			resultHigh <= primary.align ? {4'h0, d[11:8]} : d[11:4];
			resultLow <= primary.align ? d[7:0] : {d[3:0], 4'h0};
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			conversionDone <= 1'b0;
		end else begin
			conversionDone <= lastClock;
		end
	end

	// ****************************************
	// Analog routing and outputs
	// ****************************************
	wire [2:0] src = settings.source;
	wire isAmp = src == adc_ctrl_pkg::SRC_AMPLIFIED;
	wire isGnd = src >= adc_ctrl_pkg::SRC_GND_LO && src <= adc_ctrl_pkg::SRC_GND_HI;
	wire isExt = !isAmp && !isGnd;
	wire chanValid = primary.channel <= adc_ctrl_pkg::CHAN_LAST;
	wire [6:0] chanOn;
	wire supplyRef = settings.reference == adc_ctrl_pkg::REF_SUPPLY;
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : chanDecode
			assign chanOn[g] = isExt && chanValid && primary.channel == 4'(g);
		end
	endgenerate
	// One driver for the whole struct, field-wise assigns would be several
	assign route = {isExt, isAmp, isGnd, chanOn, supplyRef};
	assign converterPower = primary.power;
	assign converterClockEn = tick;
	assign sampling = busy && clocks < adc_ctrl_pkg::SAMPLE_CLOCKS;

	always_comb begin
		case (address)
			adc_ctrl_pkg::OFS_PRIMARY: readByte = {primary.start, busy, primary.power,
				primary.align, primary.channel};
			adc_ctrl_pkg::OFS_CONFIG: readByte = settings;
			adc_ctrl_pkg::OFS_RES_HIGH: readByte = resultHigh;
			adc_ctrl_pkg::OFS_RES_LOW: readByte = resultLow;
			default: readByte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			readdata <= 32'h0000_0000;
		end else if (read && !answered) begin
			readdata <= {24'h00_0000, readByte};
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	sequence s_launch;
		launch ##1 busy;
	endsequence
	a_busy_set: assert property (@(posedge mclk) disable iff (rst)
		launch |=> busy)
		else $error("busy not set after start");
	a_busy_launch: assert property (@(posedge mclk) disable iff (rst)
		$rose(busy) |-> $past(launch))
		else $error("busy rose without start sequence");
	a_busy_clear: assert property (@(posedge mclk) disable iff (rst)
		lastClock |=> !busy && conversionDone)
		else $error("busy not cleared at end");
	a_done_pulse: assert property (@(posedge mclk) disable iff (rst)
		conversionDone |-> $fell(busy))
		else $error("done without completion");
	// Power-down aborts a conversion on purpose
	a_short_conv: assert property (@(posedge mclk) disable iff (rst || !primary.power)
		s_launch |-> busy[*8])
		else $error("conversion ended too soon");
	a_result_hold: assert property (@(posedge mclk) disable iff (rst)
		!primary.power |=> $stable(resultLow) && $stable(resultHigh))
		else $error("result changed while disabled");
	a_result_fresh: assert property (@(posedge mclk) disable iff (rst)
		$fell(busy) && $past(primary.power) && $past(primary.align)
		|-> resultLow == $past(d[7:0]))
		else $error("result not updated at busy clear");
	a_align_high: assert property (@(posedge mclk) disable iff (rst)
		$past(primary.align) && $fell(busy) && $past(primary.power) |-> resultHigh[7:4] == 4'h0)
		else $error("right alignment high nibble not zero");
	a_route_excl: assert property (@(posedge mclk) disable iff (rst)
		$onehot({route.external, route.amplified, route.ground}))
		else $error("source decode not exclusive");
	a_chan_float: assert property (@(posedge mclk) disable iff (rst)
		!chanValid |-> route.channelOn == 7'h00)
		else $error("invalid channel connected");
	a_ref_supply: assert property (@(posedge mclk) disable iff (rst)
		route.supplyRef == (settings.reference == 2'h1))
		else $error("reference select wrong");
	a_power_off: assert property (@(posedge mclk) disable iff (rst)
		!primary.power |=> !busy)
		else $error("busy while powered down");
endmodule
`default_nettype wire

// ---- hw/clock_divider.sv ----
// Power-of-two divider producing a one-cycle converter clock enable
`timescale 1ns/1ns
`default_nettype none
module clock_divider (
	input wire logic mclk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] divider,
	output logic tick
);
	logic [6:0] count;
	logic [6:0] limit;
	assign limit = 7'((8'h01 << divider) - 8'h01);
	assign tick = run && (count == limit);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count <= 7'h00;
		end else if (!run || tick) begin
			count <= 7'h00;
		end else begin
			count <= count + 7'h01;
		end
	end
	a_tick_rate: assert property (@(posedge mclk) disable iff (rst)
		tick && divider == 3'h1 && $stable(divider) |=> !tick ##1 (tick || !run || $changed(divider)))
		else $error("converter clock enable spacing wrong");
endmodule
`default_nettype wire

// ---- verification/analog_input_model.sv ----
// Far-side model: analog inputs that feed the converter result
`timescale 1ns/1ns
`default_nettype none
module analog_input_model (
	input wire logic mclk,
	input wire logic converterPower,
	input wire adc_ctrl_pkg::route_t route,
	input wire logic [11:0] level,
	output logic [11:0] converterData
);
	logic [11:0] noise = 12'h5a5;
	// **********************
	// Input selection
	// **********************
	// Unpowered or floating input wanders every cycle, never a stale value
	always @(posedge mclk) begin
		noise <= ~noise ^ {noise[10:0], noise[11]};
	end
	always_comb begin
		converterData = noise;
		if (converterPower && route.ground) begin
			converterData = 12'h000;
		end else if (converterPower && route.amplified) begin
			converterData = ~level;
		end else if (converterPower && route.external && route.channelOn != 7'h00) begin
			converterData = level + {5'h00, route.channelOn};
		end
	end
endmodule
`default_nettype wire

// ---- verification/tb_adc_sequencer_control.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_adc_sequencer_control;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic [11:0] converterData;
	logic [11:0] level = 12'h000;
	logic converterPower, converterClockEn, sampling, conversionDone;
	adc_ctrl_pkg::route_t route;
	int bad_count = 0;
	int cmp_count = 0;
	int ticks = 0, sampled = 0, cycles = 0, dones = 0;
	logic [15:0] rnd = 16'h000c;
	logic [7:0] q, eH, eL;
	always #5 mclk = ~mclk;
	adc_sequencer_control adc_sequencer_control_i (.mclk(mclk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .converterData(converterData),
		.converterPower(converterPower), .converterClockEn(converterClockEn),
		.sampling(sampling), .route(route), .conversionDone(conversionDone));
	analog_input_model analog_input_model_i (.mclk(mclk), .converterPower(converterPower),
		.route(route), .level(level), .converterData(converterData));
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		ticks <= ticks + int'(converterClockEn);
		sampled <= sampled + int'(sampling);
		dones <= dones + int'(conversionDone);
	end
	// **********************
	// Helpers
	// **********************
	function automatic logic [15:0] nextRand(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Holds the request until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		address <= a;
		read <= ~wr;
		write <= wr;
		writedata <= {24'h000000, d};
		@(posedge mclk);
		while (waitrequest !== 1'b0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		check({31'h0, waitrequest}, 32'h0, "waitrequest");
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		bus(1'b0, a, 8'h00);
		check({24'h0, q}, {24'h0, exp}, what);
	endtask
	task automatic convert(input int d, input logic [2:0] s, input logic [3:0] ch, input logic al);
		logic [11:0] v;
		int n;
		@(posedge mclk);
		level <= rnd[11:0];
		v = (s == 3'h1) ? ~rnd[11:0] : (s inside {3'h2, 3'h3, 3'h4}) ? 12'h000
			: rnd[11:0] + 12'(1 << ch);
		rnd = nextRand(rnd);
		eH = al ? {4'h0, v[11:8]} : v[11:4];
		eL = al ? v[7:0] : {v[3:0], 4'h0};
		bus(1'b1, 4'h0, {3'h1, al, ch});
		bus(1'b1, 4'h4, {s, 2'h0, d[2:0]});
		bus(1'b1, 4'h0, {3'h5, al, ch});
		@(negedge mclk);
		{ticks, sampled, cycles, dones} = '0;
		bus(1'b1, 4'h0, {3'h1, al, ch});
		rd(4'h0, {3'h3, al, ch}, "busy set");
		n = 0;
		while (dones == 0 && n < 2200) begin
			@(negedge mclk);
			n++;
		end
		check(cycles >= (16 << d) && cycles <= (16 << d) + 8, 1, "duration");
		check(ticks, 16, "converter clocks");
		check(sampled >= (4 << d) - 2 && sampled <= (4 << d) + 2, 1, "sampling");
		check(dones, 1, "done pulse");
		rd(4'h0, {3'h1, al, ch}, "busy clear");
		rd(4'h8, eH, "result high");
		rd(4'hc, eL, "result low");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// **********************
	// Scenarios
	// **********************
	initial begin
		logic [3:0] ch;
		logic ext;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd(4'h0, 8'h00, "primary reset");
		rd(4'h4, 8'h00, "config reset");
		rd(4'h2, 8'h00, "unmapped");
		for (int s = 0; s < 8; s++) begin
			for (int k = 0; k < 4; k++) begin
				ch = (s == 1) ? 4'h7 + 4'(k * 2) : 4'(k * 5);
				bus(1'b1, 4'h0, {4'h0, ch});
				bus(1'b1, 4'h4, {3'(s), 2'(k), 3'h0});
				@(negedge mclk);
				ext = (s == 0 || s > 4);
				check(route, {ext, s == 1, s > 1 && s < 5, (ext && ch < 7) ? 7'(1 << ch) : 7'h0,
					k == 1}, "route");
			end
		end
		convert(0, 3'h0, 4'h3, 1'b0);
		convert(2, 3'h1, 4'hf, 1'b1);
		convert(7, 3'h3, 4'h9, 1'b0);
		convert(1, 3'h5, 4'h6, 1'b1);
		bus(1'b1, 4'h0, 8'h60);
		rd(4'h0, 8'h20, "busy read only");
		check(converterPower, 1, "power on");
		@(posedge mclk);
		level <= rnd[11:0];
		dones = 0;
		bus(1'b1, 4'h0, 8'h80);
		bus(1'b1, 4'h0, 8'h00);
		@(negedge mclk);
		check(converterPower, 0, "power off");
		repeat (40) @(negedge mclk);
		check(dones, 0, "no conversion unpowered");
		rd(4'h8, eH, "high frozen");
		rd(4'hc, eL, "low frozen");
		byteenable <= 4'h0;
		bus(1'b1, 4'h4, 8'hff);
		byteenable <= 4'hf;
		rd(4'h4, 8'ha1, "masked write ignored");
		test_done();
	end
	initial begin
		#300000;
		bad_count++;
		test_done();
	end
endmodule
`default_nettype wire
